// file: logic/fp_unit_pkg.sv
package fp_unit_pkg;
  localparam int          FP_REGS     = 32;
  localparam int          DATA_W      = 32;
  localparam int          FP_IDX_W    = 5;
  localparam int          CORE_IDX_W  = 4;
  localparam int          CNT_W       = 6;
  localparam int          SIGN_BIT    = 31;
  localparam int          FLAG_HI     = 31;
  localparam int          FLAG_LO     = 28;
  localparam logic [31:0] SIGN_MASK   = 32'h8000_0000;
  localparam logic [31:0] QNAN        = 32'h7FC0_0000;
  localparam logic [31:0] STACK_STEP  = 32'h0000_0004;
  localparam logic [31:0] FP_STATUS_CONTROL_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] BANK_RESET  = 32'h0000_0000;
  localparam logic [3:0]  CORE_SP     = 4'hD;
  localparam logic [3:0]  CORE_PC     = 4'hF;
  localparam logic [7:0]  EXP_MAX     = 8'hFF;
  localparam logic [10:0] EXP_BIAS    = 11'h07F;

  typedef enum logic [4:0] {
    OP_MOV_IMM = 5'h00,
    OP_MOV_S   = 5'h01,
    OP_MOV_D   = 5'h02,
    OP_HALF_RD = 5'h03,
    OP_S_XFER  = 5'h04,
    OP_PAIR    = 5'h05,
    OP_D_XFER  = 5'h06,
    OP_HALF_WR = 5'h07,
    OP_STAT_RD = 5'h08,
    OP_STAT_WR = 5'h09,
    OP_MUL     = 5'h0A,
    OP_NEG     = 5'h0B,
    OP_NMLA    = 5'h0C,
    OP_NMLS    = 5'h0D,
    OP_NMUL    = 5'h0E,
    OP_POP     = 5'h0F
  } fp_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_POP  = 2'b10
  } pop_state_t;
endpackage

// file: logic/fp_arith_if.sv
interface fp_arith_if;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] op_c;
  logic        neg_prod;
  logic        accumulate;
  logic [31:0] result;

  modport client (output op_a, op_b, op_c, neg_prod, accumulate,
                  input result);
  modport unit   (input op_a, op_b, op_c, neg_prod, accumulate,
                  output result);
endinterface

// file: logic/fp_arith_unit.sv
module fp_arith_unit
  import fp_unit_pkg::*;
(
  fp_arith_if.unit ar
);
  // Subnormals flush to zero; the product is rounded before the add.
  function automatic logic [31:0] pack(input logic s,
                                       input logic signed [10:0] e,
                                       input logic [26:0] m);
    logic        inc;
    logic [24:0] mr;
    logic signed [10:0] ef;
    inc = m[2] & (m[1] | m[0] | m[3]);
    mr  = {1'b0, m[26:3]} + {24'h000000, inc};
    ef  = mr[24] ? e + 11'sd1 : e;
    if (mr[24]) mr = mr >> 1;
    if (ef >= 11'sd255) return {s, EXP_MAX, 23'h000000};
    if (ef <= 11'sd0) return {s, 31'h00000000};
    return {s, ef[7:0], mr[22:0]};
  endfunction

  function automatic logic [31:0] fmul(input logic [31:0] x,
                                       input logic [31:0] y);
    logic        s;
    logic [47:0] p;
    logic signed [10:0] e;
    logic        xz, yz, xi, yi;
    s  = x[31] ^ y[31];
    xz = (x[30:23] == 8'h00);
    yz = (y[30:23] == 8'h00);
    xi = (x[30:23] == EXP_MAX);
    yi = (y[30:23] == EXP_MAX);
    p  = {1'b1, x[22:0]} * {1'b1, y[22:0]};
    e  = $signed({3'b000, x[30:23]}) + $signed({3'b000, y[30:23]})
         - $signed(EXP_BIAS);
    if ((xi && x[22:0] != 23'h0) || (yi && y[22:0] != 23'h0)) return QNAN;
    if ((xi && yz) || (yi && xz)) return QNAN;
    if (xi || yi) return {s, EXP_MAX, 23'h000000};
    if (xz || yz) return {s, 31'h00000000};
    if (p[47]) return pack(s, e + 11'sd1, {p[47:22], |p[21:0]});
    return pack(s, e, {p[46:21], |p[20:0]});
  endfunction

  function automatic logic [31:0] fadd(input logic [31:0] x0,
                                       input logic [31:0] y0);
    logic [31:0] x, y;
    logic [26:0] mx, my, msh;
    logic [27:0] sum;
    logic [7:0]  d;
    logic [4:0]  lz;
    logic        st, found;
    if ((x0[30:23] == EXP_MAX && x0[22:0] != 23'h0) ||
        (y0[30:23] == EXP_MAX && y0[22:0] != 23'h0)) return QNAN;
    if (x0[30:23] == EXP_MAX && y0[30:23] == EXP_MAX)
      return (x0[31] != y0[31]) ? QNAN : x0;
    if (x0[30:23] == EXP_MAX) return x0;
    if (y0[30:23] == EXP_MAX) return y0;
    if (x0[30:23] == 8'h00 && y0[30:23] == 8'h00)
      return {x0[31] & y0[31], 31'h00000000};
    if (x0[30:23] == 8'h00) return y0;
    if (y0[30:23] == 8'h00) return x0;
    x   = (x0[30:0] >= y0[30:0]) ? x0 : y0;
    y   = (x0[30:0] >= y0[30:0]) ? y0 : x0;
    mx  = {1'b1, x[22:0], 3'b000};
    my  = {1'b1, y[22:0], 3'b000};
    d   = x[30:23] - y[30:23];
    msh = (d > 8'd26) ? 27'h0 : my >> d;
    st  = (d > 8'd26) ? 1'b1 : (msh << d) != my;
    msh = {msh[26:1], msh[0] | st};
    sum = (x[31] == y[31]) ? {1'b0, mx} + {1'b0, msh}
                           : {1'b0, mx} - {1'b0, msh};
    if (sum == 28'h0) return 32'h0000_0000;
    if (sum[27])
      return pack(x[31], $signed({3'b000, x[30:23]}) + 11'sd1,
                  {sum[27:2], sum[1] | sum[0]});
    lz    = 5'd0;
    found = 1'b0;
    for (int i = 26; i >= 0; i--) begin
      if (!found && sum[i]) found = 1'b1;
      else if (!found) lz = lz + 5'd1;
    end
    return pack(x[31], $signed({3'b000, x[30:23]}) - $signed({6'h00, lz}),
                sum[26:0] << lz);
  endfunction

  logic [31:0] prod;

  assign prod = fmul(ar.op_a, ar.op_b) ^ (ar.neg_prod ? SIGN_MASK : 32'h0);
  assign ar.result = ar.accumulate ? fadd(ar.op_c ^ SIGN_MASK, prod) : prod;
endmodule // fp_arith_unit

// file: logic/fp_move_multiply_negate_unit.sv
// Function
// RULE1: Move-immediate expands the 8-bit constant into the chosen single.
// RULE2: Register move copies a whole single or a whole double.
// RULE3: Half read sends the lower (0) or upper (1) double word to core.
// RULE4: Core never names PC or SP in single, pair or status transfers.
// RULE5: Single transfer moves a word either way between single and core.
// RULE6: Pair moves first core word with named single, second with next.
// RULE7: Double transfer moves two words between core pair and double.
// RULE8: First core register is the lower word, second the upper word.
// RULE9: Half write replaces one double half, keeping the other intact.
// RULE10: Status read copies the whole status register to a core register.
// RULE11: Status read to the flag set copies N, Z, C, V to the core.
// RULE12: Only status read to the flag set touches the core flags.
// RULE13: Status write loads a core register into the status register.
// RULE14: Multiply writes the product; omitted destination means first operand.
// RULE15: Negate writes the source with only the sign bit inverted.
// RULE16: Neg-mul-accumulate writes minus destination minus product.
// RULE17: Neg-mul-subtract writes minus destination plus product.
// RULE18: Neg-multiply writes the negated product.
// RULE19: Pop loads consecutive singles or doubles from successive stack words.
// RULE20: A pop list holds one to sixteen registers.
// RULE21: Any pop size given equals the listed register width.
// RULE22: A failed condition leaves registers, memory and flags unchanged.
module fp_move_multiply_negate_unit
  import fp_unit_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire fp_unit_pkg::fp_op_t  cmd_op,
  input  wire logic                 cond_pass,
  input  wire logic                 dest_omitted,
  input  wire logic                 to_core,
  input  wire logic                 to_flags,
  input  wire logic                 pop_double,
  input  wire logic                 half_sel,
  input  wire logic [4:0]           fd,
  input  wire logic [4:0]           fn,
  input  wire logic [4:0]           fm,
  input  wire logic [7:0]           imm8,
  input  wire logic [4:0]           pop_count,
  input  wire logic [3:0]           core_idx_a,
  input  wire logic [3:0]           core_idx_b,
  input  wire logic [31:0]          core_data_a,
  input  wire logic [31:0]          core_data_b,
  input  wire logic [31:0]          stack_ptr,
  output logic                      core_wr_en_a,
  output logic [3:0]                core_wr_idx_a,
  output logic [31:0]               core_wr_data_a,
  output logic                      core_wr_en_b,
  output logic [3:0]                core_wr_idx_b,
  output logic [31:0]               core_wr_data_b,
  output logic                      flags_wr,
  output logic [3:0]                flags_nzcv,
  output logic [31:0]               fp_status_control_reg_value,
  output logic                      sp_wr,
  output logic [31:0]               sp_wr_data,
  output logic                      mem_rd_req,
  output logic [31:0]               mem_addr,
  input  wire logic [31:0]          mem_rdata,
  input  wire logic                 mem_rvalid,
  input  wire logic [4:0]           fp_rd_idx,
  output logic [31:0]               fp_rd_data,
  output logic                      done
);
  // Constant layout: sign, inverted-then-replicated exponent, 4 fraction bits
  function automatic logic [31:0] expand_imm(input logic [7:0] v);
    return {v[7], ~v[6], {5{v[6]}}, v[5:4], v[3:0], 19'h00000};
  endfunction

  logic [31:0]  bank [FP_REGS];
  logic [31:0]  fp_status_control_reg;
  pop_state_t   state;
  logic [31:0]  pop_addr;
  logic [4:0]   pop_idx;
  logic [CNT_W-1:0] pop_left;

  fp_arith_if ar ();

  fp_arith_unit fp_arith_unit_inst (
    .ar (ar.unit)
  );

  logic        take;
  logic        exec;
  logic        is_mov_imm, is_mov_s, is_mov_d, is_half_rd, is_half_wr;
  logic        is_s_xfer, is_pair, is_d_xfer, is_stat_rd, is_stat_wr;
  logic        is_mul, is_neg, is_nmla, is_nmls, is_nmul, is_pop, is_arith;
  logic [4:0]  dst_idx;
  logic [4:0]  dm_lo, dm_hi, dd_lo, dd_hi, fm_next, half_rd_idx, half_wr_idx;
  logic [4:0]  half_keep_idx;
  logic [31:0] half_rd_word, dm_lo_word, dm_hi_word, src_word, next_word;
  logic        pop_wr;
  logic        pop_last;
  logic        wr0_en, wr1_en;
  logic [4:0]  wr0_idx, wr1_idx;
  logic [31:0] wr0_data, wr1_data;
  logic        next_ca_en, next_cb_en;
  logic [31:0] next_ca_data, next_cb_data;
  logic        next_done;

  assign cmd_ready  = (state == ST_IDLE);
  assign take       = cmd_valid & cmd_ready;
  assign exec       = take & cond_pass;                          // RULE22
  assign is_mov_imm = (cmd_op == OP_MOV_IMM);
  assign is_mov_s   = (cmd_op == OP_MOV_S);
  assign is_mov_d   = (cmd_op == OP_MOV_D);
  assign is_half_rd = (cmd_op == OP_HALF_RD);
  assign is_half_wr = (cmd_op == OP_HALF_WR);
  assign is_s_xfer  = (cmd_op == OP_S_XFER);
  assign is_pair    = (cmd_op == OP_PAIR);
  assign is_d_xfer  = (cmd_op == OP_D_XFER);
  assign is_stat_rd = (cmd_op == OP_STAT_RD);
  assign is_stat_wr = (cmd_op == OP_STAT_WR);
  assign is_mul     = (cmd_op == OP_MUL);
  assign is_neg     = (cmd_op == OP_NEG);
  assign is_nmla    = (cmd_op == OP_NMLA);
  assign is_nmls    = (cmd_op == OP_NMLS);
  assign is_nmul    = (cmd_op == OP_NMUL);
  assign is_pop     = (cmd_op == OP_POP);
  assign is_arith   = is_mul | is_nmla | is_nmls | is_nmul;

  // Doubles D0..D15 overlay single pairs; the low single is the low word
  assign dst_idx       = (is_mul && dest_omitted) ? fn : fd;     // RULE14
  assign dm_lo         = {fm[3:0], 1'b0};                        // RULE8
  assign dm_hi         = {fm[3:0], 1'b1};
  assign dd_lo         = {fd[3:0], 1'b0};
  assign dd_hi         = {fd[3:0], 1'b1};
  assign fm_next       = fm + 5'd1;                              // RULE6
  assign half_rd_idx   = {fm[3:0], half_sel};                    // RULE3
  assign half_wr_idx   = {fd[3:0], half_sel};                    // RULE9
  assign half_keep_idx = {fd[3:0], ~half_sel};
  assign half_rd_word  = bank[half_rd_idx];
  assign dm_lo_word    = bank[dm_lo];
  assign dm_hi_word    = bank[dm_hi];
  assign src_word      = bank[fm];
  assign next_word     = bank[fm_next];

  assign ar.op_a       = bank[fn];
  assign ar.op_b       = bank[fm];
  assign ar.op_c       = bank[fd];
  assign ar.neg_prod   = is_nmul | is_nmla;                      // RULE16
  assign ar.accumulate = is_nmla | is_nmls;                      // RULE17

  assign pop_wr   = (state == ST_POP) & mem_rvalid;
  assign pop_last = pop_wr & (pop_left == 6'd1);

  assign wr0_en = pop_wr |
                  (exec & (is_mov_imm | is_mov_s | is_mov_d | is_neg |
                           is_arith | is_half_wr |
                           ((is_s_xfer | is_pair | is_d_xfer) & ~to_core)));
  assign wr0_idx = pop_wr                   ? pop_idx :
                   is_mov_d                 ? dd_lo :
                   is_d_xfer                ? dm_lo :           // RULE8
                   is_half_wr               ? half_wr_idx :     // RULE9
                   is_arith                 ? dst_idx :
                   (is_s_xfer | is_pair)    ? fm : fd;
  assign wr0_data = pop_wr     ? mem_rdata :                    // RULE19
                    is_mov_imm ? expand_imm(imm8) :             // RULE1
                    is_mov_s   ? src_word :                     // RULE2
                    is_mov_d   ? dm_lo_word :                   // RULE2
                    is_neg     ? src_word ^ SIGN_MASK :         // RULE15
                    is_arith   ? ar.result :                    // RULE18
                    core_data_a;                                 // RULE5
  assign wr1_en   = exec & (is_mov_d | ((is_pair | is_d_xfer) & ~to_core));
  assign wr1_idx  = is_mov_d ? dd_hi : is_d_xfer ? dm_hi : fm_next; // RULE7
  assign wr1_data = is_mov_d ? dm_hi_word : core_data_b;

  // Core-side results; PC and SP are never named here by the issuer
  assign next_ca_en = exec & (is_half_rd | (is_stat_rd & ~to_flags) |
                      ((is_s_xfer | is_pair | is_d_xfer) & to_core)); // RULE4
  assign next_ca_data = is_stat_rd ? fp_status_control_reg :                     // RULE10
                        is_half_rd ? half_rd_word :              // RULE3
                        is_d_xfer  ? dm_lo_word :                // RULE8
                        src_word;                                // RULE5
  assign next_cb_en   = exec & (is_pair | is_d_xfer) & to_core;  // RULE7
  assign next_cb_data = is_d_xfer ? dm_hi_word : next_word;      // RULE6
  assign next_done    = (take & ~(cond_pass & is_pop)) | pop_last;
  assign mem_rd_req   = (state == ST_POP);
  assign mem_addr     = pop_addr;
  assign fp_status_control_reg_value  = fp_status_control_reg;

  // Two write ports so pairs and doubles land in one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < FP_REGS; i++) bank[i] <= BANK_RESET;
    end else begin
      if (wr0_en) bank[wr0_idx] <= wr0_data;
      if (wr1_en) bank[wr1_idx] <= wr1_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fp_status_control_reg <= FP_STATUS_CONTROL_REG_RESET;
    end else if (exec && is_stat_wr) begin
      fp_status_control_reg <= core_data_a;                                      // RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_wr_en_a   <= 1'b0;
      core_wr_idx_a  <= 4'h0;
      core_wr_data_a <= 32'h0000_0000;
      core_wr_en_b   <= 1'b0;
      core_wr_idx_b  <= 4'h0;
      core_wr_data_b <= 32'h0000_0000;
      fp_rd_data     <= 32'h0000_0000;
      done           <= 1'b0;
    end else begin
      core_wr_en_a   <= next_ca_en;
      core_wr_idx_a  <= core_idx_a;
      core_wr_data_a <= next_ca_data;
      core_wr_en_b   <= next_cb_en;
      core_wr_idx_b  <= core_idx_b;
      core_wr_data_b <= next_cb_data;
      fp_rd_data     <= bank[fp_rd_idx];
      done           <= next_done;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_wr   <= 1'b0;
      flags_nzcv <= 4'h0;
    end else begin
      flags_wr <= exec & is_stat_rd & to_flags;                  // RULE12
      if (exec && is_stat_rd && to_flags)
        flags_nzcv <= fp_status_control_reg[FLAG_HI:FLAG_LO];                    // RULE11
    end
  end

  // One read outstanding at a time keeps the memory side trivial
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      pop_addr   <= 32'h0000_0000;
      pop_idx    <= 5'h00;
      pop_left   <= 6'h00;
      sp_wr      <= 1'b0;
      sp_wr_data <= 32'h0000_0000;
    end else begin
      sp_wr <= pop_last;
      case (state)
        ST_IDLE: begin
          if (exec && is_pop) begin                              // RULE19
            state    <= ST_POP;
            pop_addr <= stack_ptr;
            pop_idx  <= pop_double ? dd_lo : fd;
            pop_left <= pop_double ? {pop_count, 1'b0}           // RULE21
                                   : {1'b0, pop_count};          // RULE20
          end
        end
        ST_POP: begin
          if (pop_wr) begin
            pop_addr <= pop_addr + STACK_STEP;
            pop_idx  <= pop_idx + 5'd1;
            pop_left <= pop_left - 6'd1;
            if (pop_last) begin
              state      <= ST_IDLE;
              sp_wr_data <= pop_addr + STACK_STEP;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  property p_mov_imm;
    @(posedge clk) disable iff (!rst_n)
    exec && is_mov_imm |=> bank[$past(fd)] == expand_imm($past(imm8));
  endproperty
  a_mov_imm: assert property (p_mov_imm) // RULE1
    else $error("immediate move wrote wrong value");

  property p_half_rd;
    @(posedge clk) disable iff (!rst_n)
    exec && is_half_rd |=> core_wr_en_a &&
      core_wr_data_a == $past(half_rd_word);
  endproperty
  a_half_rd: assert property (p_half_rd) // RULE3
    else $error("half read returned wrong word");

  property p_half_wr;
    @(posedge clk) disable iff (!rst_n)
    exec && is_half_wr |=> bank[$past(half_wr_idx)] == $past(core_data_a)
      && bank[$past(half_keep_idx)] == $past(bank[half_keep_idx]);
  endproperty
  a_half_wr: assert property (p_half_wr) // RULE9
    else $error("half write damaged the double");

  property p_d_to_core;
    @(posedge clk) disable iff (!rst_n)
    exec && is_d_xfer && to_core |=> core_wr_en_a && core_wr_en_b &&
      core_wr_data_a == $past(dm_lo_word) &&
      core_wr_data_b == $past(dm_hi_word);
  endproperty
  a_d_to_core: assert property (p_d_to_core) // RULE8
    else $error("double transfer word order wrong");

  property p_flags_only;
    @(posedge clk) disable iff (!rst_n)
    flags_wr |-> $past(exec && is_stat_rd && to_flags) &&
      flags_nzcv == $past(fp_status_control_reg[FLAG_HI:FLAG_LO]);
  endproperty
  a_flags_only: assert property (p_flags_only) // RULE12
    else $error("flags changed by wrong operation");

  property p_stat_wr;
    @(posedge clk) disable iff (!rst_n)
    exec && is_stat_wr |=> fp_status_control_reg == $past(core_data_a);
  endproperty
  a_stat_wr: assert property (p_stat_wr) // RULE13
    else $error("status write not loaded");

  property p_neg;
    @(posedge clk) disable iff (!rst_n)
    exec && is_neg |=> bank[$past(fd)] == ($past(src_word) ^ SIGN_MASK);
  endproperty
  a_neg: assert property (p_neg) // RULE15
    else $error("negate changed more than the sign");

  property p_pop_word;
    @(posedge clk) disable iff (!rst_n)
    pop_wr |=> bank[$past(pop_idx)] == $past(mem_rdata) &&
      mem_addr == $past(mem_addr) + STACK_STEP;
  endproperty
  a_pop_word: assert property (p_pop_word) // RULE19
    else $error("pop word misplaced");

  property p_cond_fail;
    @(posedge clk) disable iff (!rst_n)
    take && !cond_pass |=> !core_wr_en_a && !core_wr_en_b && !flags_wr &&
      $stable(fp_status_control_reg) && state == ST_IDLE && done;
  endproperty
  a_cond_fail: assert property (p_cond_fail) // RULE22
    else $error("failed condition had an effect");

  c_pop_end:  cover property (@(posedge clk) disable iff (!rst_n) sp_wr);
  c_flags:    cover property (@(posedge clk) disable iff (!rst_n) flags_wr);
  c_nmla:     cover property (@(posedge clk) disable iff (!rst_n)
                              exec && is_nmla);
  c_pair_in:  cover property (@(posedge clk) disable iff (!rst_n)
                              exec && is_pair && !to_core);
endmodule // fp_move_multiply_negate_unit

// file: verification/stack_mem_model.sv
module stack_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        mem_rd_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  lat,
  output logic [31:0]      mem_rdata,
  output logic             mem_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] WORD_KEY = 32'hC0DE_0000;
  logic [3:0] waited;
  // Data toggles between answers so a stale word can never pass as fresh
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= 32'h0000_0000;
      waited     <= 4'h0;
    end else if (mem_rd_req && !mem_rvalid && waited == lat) begin
      mem_rvalid <= 1'b1;
      mem_rdata  <= mem_addr ^ WORD_KEY;
      waited     <= 4'h0;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      waited     <= (mem_rd_req && !mem_rvalid) ? waited + 4'h1 : 4'h0;
    end
  end
endmodule // stack_mem_model

// file: verification/fp_move_multiply_negate_unit_test.sv
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module fp_move_multiply_negate_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  import fp_unit_pkg::*;
  localparam logic [4:0]  NC = 5'h10, TC = 5'h08, TF = 5'h04;
  localparam logic [4:0]  HS = 5'h02, DB = 5'h01, Z5 = 5'h00;
  localparam logic [31:0] KA = 32'h1234_5678, KB = 32'h0BAD_F00D;
  localparam logic [31:0] KEY = 32'hC0DE_0000;
  logic        clk, rst_n, cmd_valid, cmd_ready, cond_pass, dest_omitted;
  logic        to_core, to_flags, pop_double, half_sel, core_wr_en_a;
  logic        core_wr_en_b, flags_wr, sp_wr, mem_rd_req, mem_rvalid;
  logic        done, saw_busy;
  fp_op_t      cmd_op;
  logic [4:0]  fd, fn, fm, pop_count, fp_rd_idx;
  logic [7:0]  imm8;
  logic [3:0]  core_idx_a, core_idx_b, core_wr_idx_a, core_wr_idx_b;
  logic [3:0]  flags_nzcv, lat;
  logic [31:0] core_data_a, core_data_b, stack_ptr, core_wr_data_a;
  logic [31:0] core_wr_data_b, fp_status_control_reg_value, sp_wr_data, mem_addr;
  logic [31:0] mem_rdata, fp_rd_data;
  int          num_errors, total_checks;

  fp_move_multiply_negate_unit fp_move_multiply_negate_unit_inst (.*);
  stack_mem_model stack_mem_model_inst (.*);

  task automatic end_of_test;
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Offers one command and waits for its completion pulse
  task automatic cmd(input fp_op_t op, input logic [4:0] d, n, m, f,
                     input logic [31:0] x);
    int k;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    fd <= d;
    fn <= n;
    fm <= m;
    {cond_pass, to_core, to_flags, half_sel, dest_omitted} <= f ^ NC;
    pop_double <= f[0];
    pop_count <= n;
    imm8 <= x[7:0];
    core_data_a <= x;
    core_data_b <= ~x;
    stack_ptr <= x;
    core_idx_a <= 4'h3;
    core_idx_b <= 4'h9;
    @(posedge clk);
    cmd_valid <= 1'b0;
    saw_busy = 1'b0;
    k = 0;
    // done may already stand in the cycle right after the take edge
    #1;
    while (done !== 1'b1 && k < 60) begin
      if (cmd_ready !== 1'b1) saw_busy = 1'b1;
      @(posedge clk);
      #1;
      k++;
    end
    if (done !== 1'b1) begin
      num_errors++;
      end_of_test;
    end
    `CHK("flags_wr", f[4:2] == 3'b001 && op == OP_STAT_RD, flags_wr)
  endtask

  task automatic chkr(input string nm, input logic [4:0] i,
                      input logic [31:0] e);
    @(posedge clk);
    fp_rd_idx <= i;
    repeat (2) @(posedge clk);
    #1 `CHK(nm, e, fp_rd_data)
  endtask

  task automatic t_xfer;
    cmd(OP_S_XFER, Z5, Z5, 5'h04, Z5, KA);
    cmd(OP_S_XFER, Z5, Z5, 5'h04, TC, 32'h0);
    `CHK("wr_a", KA, core_wr_data_a)
    `CHK("idx_a", 4'h3, core_wr_idx_a)
    cmd(OP_PAIR, Z5, Z5, 5'h04, Z5, KB);
    chkr("S5", 5'h05, ~KB);
    cmd(OP_PAIR, Z5, Z5, 5'h04, TC, 32'h0);
    `CHK("pair_a", KB, core_wr_data_a)
    `CHK("pair_b", ~KB, core_wr_data_b)
    cmd(OP_D_XFER, Z5, Z5, 5'h02, TC, 32'h0);
    `CHK("wr_a", KB, core_wr_data_a)
    `CHK("wr_b", ~KB, core_wr_data_b)
    `CHK("en_b", 1'b1, core_wr_en_b)
    `CHK("idx_b", 4'h9, core_wr_idx_b)
    cmd(OP_D_XFER, Z5, Z5, 5'h03, Z5, KA);
    chkr("S7", 5'h07, ~KA);
    for (int h = 0; h < 2; h++) begin
      cmd(OP_HALF_RD, Z5, Z5, 5'h02, h[0] ? HS : Z5, 32'h0);
      `CHK("half", h[0] ? ~KB : KB, core_wr_data_a)
    end
    cmd(OP_HALF_WR, 5'h02, Z5, Z5, Z5, KA);
    chkr("S4", 5'h04, KA);
    chkr("S5", 5'h05, ~KB);
    cmd(OP_MOV_D, 5'h06, Z5, 5'h02, Z5, 32'h0);
    chkr("S13", 5'h0D, ~KB);
    cmd(OP_MOV_S, 5'h0B, Z5, 5'h04, Z5, 32'h0);
    chkr("S11", 5'h0B, KA);
  endtask

  task automatic t_status;
    cmd(OP_STAT_WR, Z5, Z5, Z5, Z5, 32'hA000_0005);
    `CHK("fp_status_control_reg", 32'hA000_0005, fp_status_control_reg_value)
    cmd(OP_STAT_RD, Z5, Z5, Z5, Z5, 32'h0);
    `CHK("stat", 32'hA000_0005, core_wr_data_a)
    cmd(OP_STAT_RD, Z5, Z5, Z5, TF, 32'h0);
    `CHK("nzcv", 4'hA, flags_nzcv)
  endtask

  task automatic t_pop;
    lat = 4'h2;
    cmd(OP_POP, Z5, 5'h02, Z5, DB, 32'h0000_0100);
    `CHK("sp_wr", 1'b1, sp_wr)
    `CHK("sp", 32'h0000_0110, sp_wr_data)
    `CHK("busy", 1'b1, saw_busy)
    chkr("S0", Z5, 32'h0000_0100 ^ KEY);
    chkr("S3", 5'h03, 32'h0000_010C ^ KEY);
    lat = 4'h0;
    cmd(OP_POP, 5'h1F, 5'h01, Z5, Z5, 32'h0000_0200);
    `CHK("sp", 32'h0000_0204, sp_wr_data)
    chkr("S31", 5'h1F, 32'h0000_0200 ^ KEY);
  endtask

  task automatic t_arith;
    cmd(OP_MOV_IMM, 5'h06, Z5, Z5, Z5, 32'h00);
    cmd(OP_MOV_IMM, 5'h07, Z5, Z5, Z5, 32'h08);
    chkr("S7", 5'h07, 32'h4040_0000);
    cmd(OP_MUL, 5'h08, 5'h06, 5'h07, Z5, 32'h0);
    chkr("S8", 5'h08, 32'h40C0_0000);
    cmd(OP_NMUL, 5'h09, 5'h06, 5'h07, Z5, 32'h0);
    chkr("S9", 5'h09, 32'hC0C0_0000);
    cmd(OP_NMLA, 5'h08, 5'h06, 5'h07, Z5, 32'h0);
    chkr("S8", 5'h08, 32'hC140_0000);
    cmd(OP_NMLS, 5'h09, 5'h06, 5'h07, Z5, 32'h0);
    chkr("S9", 5'h09, 32'h4140_0000);
    cmd(OP_NEG, 5'h0A, Z5, 5'h09, Z5, 32'h0);
    chkr("S10", 5'h0A, 32'hC140_0000);
    cmd(OP_MUL, Z5, 5'h06, 5'h07, DB, 32'h0);
    chkr("S6", 5'h06, 32'h40C0_0000);
  endtask

  // Failed conditions must still complete but change nothing
  task automatic t_cond;
    cmd(OP_STAT_WR, Z5, Z5, Z5, NC, 32'h0);
    `CHK("fp_status_control_reg", 32'hA000_0005, fp_status_control_reg_value)
    cmd(OP_STAT_RD, Z5, Z5, Z5, NC | TF, 32'h0);
    `CHK("wr_en", 1'b0, core_wr_en_a)
    cmd(OP_MOV_IMM, 5'h08, Z5, Z5, NC, 32'h00);
    chkr("S8", 5'h08, 32'hC140_0000);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst_n, cmd_valid, cond_pass, dest_omitted, to_core, to_flags} = '0;
    {pop_double, half_sel, fd, fn, fm, pop_count, fp_rd_idx, imm8} = '0;
    {core_idx_a, core_idx_b, core_data_a, core_data_b, stack_ptr} = '0;
    cmd_op = OP_MOV_IMM;
    lat = 4'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_xfer;
    t_status;
    t_pop;
    t_arith;
    t_cond;
    end_of_test;
  end
endmodule // fp_move_multiply_negate_unit_test
